// [ebt_count_src.sv]
// Model of the signal source wired to the external count input.
`timescale 1ns/1ps
module ebt_count_src (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Request
  input  wire logic       start_i,
  input  wire logic [7:0] pulses_i,
  input  wire logic       level_i,
  // Line and status
  output logic            line_o,
  output logic            busy_o
);
  logic [8:0] edges_r;
  logic [2:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Edges are eight clocks apart, so the sampler never sees two in one cycle.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_o  <= 1'b0;
      edges_r <= 9'h000;
      wait_r  <= 3'h0;
    end else if (start_i) begin
      edges_r <= {pulses_i, 1'b0};
      wait_r  <= 3'h0;
      if (pulses_i == 8'h00) begin
        line_o <= level_i;
      end
    end else if (edges_r != 9'h000) begin
      wait_r <= wait_r + 3'h1;
      if (wait_r == 3'h7) begin
        line_o  <= ~line_o;
        edges_r <= edges_r - 9'h001;
      end
    end
  end

  assign busy_o = (edges_r != 9'h000);
endmodule

// [ebt_pkg.sv]
// Shared constants and types for the eight bit timer block.
package ebt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned INST_PERIOD_NS = 20;
  localparam int unsigned PHASES         = INST_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] OFS_COUNT    = 4'h0;
  localparam logic [3:0] OFS_OPTION   = 4'h1;
  localparam logic [3:0] OFS_FLAG     = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

  localparam int unsigned OPT_SOURCE = 5;
  localparam int unsigned OPT_EDGE   = 4;
  localparam int unsigned OPT_BYPASS = 3;
  localparam int unsigned FLAG_OVF   = 0;
  localparam int unsigned FLAG_IE    = 1;

  localparam logic [5:0] OPTION_RESET = 6'h3F;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] COUNT_TOP    = 8'hFF;

  typedef enum logic [2:0] {
    EBT_RUN   = 3'h1,
    EBT_HOLD1 = 3'h2,
    EBT_HOLD2 = 3'h4
  } ebt_hold_type;

endpackage

// [ebt_prescaler.sv]
// Programmable power-of-two prescaler for the eight bit timer.
`timescale 1ns/1ps

module ebt_prescaler #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             tick_i,
  input  wire logic             clr_i,
  input  wire logic             bypass_i,
  input  wire logic [2:0]       rate_i,
  // Result
  output logic                  tick_o
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] lim;
  logic             wrap;

  // Rate 7 wraps the shifted value to zero, so the limit becomes all ones.
  assign lim  = WIDTH'((WIDTH+1)'(2) << rate_i) - WIDTH'(1);
  assign wrap = (cnt_r == lim);

  assign tick_o = bypass_i ? tick_i : (tick_i & wrap);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (clr_i) begin
      cnt_r <= '0;
    end else if (tick_i && !bypass_i) begin
      cnt_r <= wrap ? '0 : cnt_r + WIDTH'(1);
    end
  end

endmodule

// [ebt_timer.sv]
// Eight bit timer/counter with prescaler, overflow flag and interrupt.
`timescale 1ns/1ps

// How it works
// - One 8-bit count register works as timer or counter by source choice.
// - Timer mode without prescaler adds one each instruction cycle.
// - Source select zero picks the instruction clock.
// - Incrementing is held off for two instruction cycles after a count write.
// - Counter mode counts rising edges, or falling edges when edge select is one.
// - Source select one picks the external count input.
// - The block owns its own 8-bit prescaler.
// - An overflow pulse is offered to gate the sixteen bit timer.
// - Bypass zero inserts prescaler dividing 1:2 to 1:256; bypass one gives 1:1.
// - Each count write clears the prescaler, which software cannot access.
// - Rollover FFh to 00h sets the overflow flag; only software clears it.
// - Counter mode samples prescaler output on Q2 and Q4 before incrementing.
module ebt_timer (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // External count input
  input  wire logic       external_count_input_i,
  // Outputs
  output logic            irq_o,
  output logic            gate_o
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0]             phase_r;
  logic [7:0]             count_register_r;
  logic [5:0]             option_r;
  logic                   overflow_flag_r;
  logic                   overflow_irq_enable_r;
  logic                   irq_stat_r;
  logic                   irq_mask_r;
  logic                   ext_prev_r;
  logic                   pend_r;
  ebt_pkg::ebt_hold_type  hold_r;
  logic                   q2_en;
  logic                   q4_en;
  logic                   wr_count;
  logic                   edge_hit;
  logic                   pre_in;
  logic                   pre_out;
  logic                   src_tick;
  logic                   inc;
  logic                   ovf;
  logic                   count_source_select;
  logic                   count_edge_select;
  logic                   prescaler_bypass;
  logic [2:0]             prescale_rate;

  assign count_source_select = option_r[ebt_pkg::OPT_SOURCE];
  assign count_edge_select   = option_r[ebt_pkg::OPT_EDGE];
  assign prescaler_bypass    = option_r[ebt_pkg::OPT_BYPASS];
  assign prescale_rate       = option_r[2:0];

  assign q2_en    = (phase_r == ebt_pkg::PHASE_Q2);
  assign q4_en    = (phase_r == ebt_pkg::PHASE_Q4);
  assign wr_count = wr_i && (addr_i == ebt_pkg::OFS_COUNT);

  ////////////////////////////////////////////////////////////////////////////////
  // Four clock phases make one instruction cycle; Q4 ends it.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= external_count_input_i;
    end
  end

  assign edge_hit = count_edge_select ? (ext_prev_r && !external_count_input_i)
                                      : (!ext_prev_r && external_count_input_i);

  assign pre_in = count_source_select ? edge_hit : q4_en;

  ebt_prescaler #(
    .WIDTH (8)
  ) u_pre (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .tick_i   (pre_in),
    .clr_i    (wr_count),
    .bypass_i (prescaler_bypass),
    .rate_i   (prescale_rate),
    .tick_o   (pre_out)
  );

  // Edges faster than two per instruction cycle are lost; the input must be slow.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 1'b0;
    end else if (!count_source_select || wr_count) begin
      pend_r <= 1'b0;
    end else if (pre_out) begin
      pend_r <= 1'b1;
    end else if (q2_en || q4_en) begin
      pend_r <= 1'b0;
    end
  end

  assign src_tick = count_source_select ? (pend_r && (q2_en || q4_en)) : pre_out;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= ebt_pkg::EBT_RUN;
    end else if (wr_count) begin
      hold_r <= ebt_pkg::EBT_HOLD2;
    end else if (q4_en) begin
      case (hold_r)
        ebt_pkg::EBT_HOLD2: begin
          hold_r <= ebt_pkg::EBT_HOLD1;
        end
        ebt_pkg::EBT_HOLD1: begin
          hold_r <= ebt_pkg::EBT_RUN;
        end
        default: begin
          hold_r <= ebt_pkg::EBT_RUN;
        end
      endcase
    end
  end

  assign inc = src_tick && (hold_r == ebt_pkg::EBT_RUN) && !wr_count;
  assign ovf = inc && (count_register_r == ebt_pkg::COUNT_TOP);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_register_r <= ebt_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_register_r <= wdata_i;
    end else if (inc) begin
      count_register_r <= count_register_r + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      option_r <= ebt_pkg::OPTION_RESET;
    end else if (wr_i && (addr_i == ebt_pkg::OFS_OPTION)) begin
      option_r <= wdata_i[5:0];
    end
  end

  // A rollover in the cycle of a clearing write keeps the flag set.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_r       <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
    end else begin
      if (wr_i && (addr_i == ebt_pkg::OFS_FLAG)) begin
        overflow_irq_enable_r <= wdata_i[ebt_pkg::FLAG_IE];
      end
      if (ovf) begin
        overflow_flag_r <= 1'b1;
      end else if (wr_i && (addr_i == ebt_pkg::OFS_FLAG)) begin
        overflow_flag_r <= wdata_i[ebt_pkg::FLAG_OVF];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= 1'b0;
    end else if (ovf) begin
      irq_stat_r <= 1'b1;
    end else if (rd_i && (addr_i == ebt_pkg::OFS_IRQ_STAT)) begin
      irq_stat_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= 1'b0;
    end else if (wr_i && (addr_i == ebt_pkg::OFS_IRQ_MASK)) begin
      irq_mask_r <= wdata_i[0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (irq_stat_r || ovf) && irq_mask_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ebt_pkg::OFS_COUNT: begin
          rdata_o <= count_register_r;
        end
        ebt_pkg::OFS_OPTION: begin
          rdata_o <= {2'h0, option_r};
        end
        ebt_pkg::OFS_FLAG: begin
          rdata_o <= {6'h00, overflow_irq_enable_r, overflow_flag_r};
        end
        ebt_pkg::OFS_IRQ_STAT: begin
          rdata_o <= {7'h00, irq_stat_r};
        end
        ebt_pkg::OFS_IRQ_MASK: begin
          rdata_o <= {7'h00, irq_mask_r};
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence count_wr_s;
    wr_i && (addr_i == ebt_pkg::OFS_COUNT);
  endsequence

  sequence flag_wr_s;
    wr_i && (addr_i == ebt_pkg::OFS_FLAG);
  endsequence

  sequence held_s;
    (hold_r != ebt_pkg::EBT_RUN) [*4];
  endsequence

  // A selected edge taken while running; with no prescaler one edge is one step.
  sequence sel_edge_s;
    count_source_select && prescaler_bypass && edge_hit && !wr_count
      && (hold_r == ebt_pkg::EBT_RUN);
  endsequence

  sequence count_moved_s;
    count_register_r != $past(count_register_r);
  endsequence

  write_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_wr_s |=> held_s)
    else $error("count advanced too soon after a write");

  write_lands_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_wr_s |=> count_register_r == $past(wdata_i))
    else $error("count write did not land");

  run_only_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (count_register_r != $past(count_register_r)) && !$past(wr_count)
      |-> $past(hold_r == ebt_pkg::EBT_RUN))
    else $error("count moved while held");

  timer_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !count_source_select && prescaler_bypass && q4_en && !wr_count
      && (hold_r == ebt_pkg::EBT_RUN) |=> count_register_r == $past(count_register_r) + 8'h01)
    else $error("timer did not step on the instruction cycle");

  timer_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !count_source_select && !q4_en && !wr_count
      |=> count_register_r == $past(count_register_r))
    else $error("timer moved off the instruction cycle");

  counter_phase_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    count_source_select && !wr_count && !(q2_en || q4_en)
      |=> count_register_r == $past(count_register_r))
    else $error("counter stepped outside Q2 or Q4");

  // The pending step is taken at the next Q2 or Q4, at most two clocks on.
  edge_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_edge_s |-> ##[2:3] count_moved_s)
    else $error("selected edge was not counted");

  ovf_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ovf |=> overflow_flag_r && (count_register_r == 8'h00))
    else $error("rollover did not set the flag");

  rollover_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (count_register_r == 8'h00) && ($past(count_register_r) == ebt_pkg::COUNT_TOP)
      && !$past(wr_count) |-> overflow_flag_r)
    else $error("rollover left the flag clear");

  flag_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    overflow_flag_r && !(wr_i && (addr_i == ebt_pkg::OFS_FLAG)) |=> overflow_flag_r)
    else $error("overflow flag dropped without a write");

  flag_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flag_wr_s ##0 !ovf |=> overflow_flag_r == $past(wdata_i[ebt_pkg::FLAG_OVF]))
    else $error("flag write did not land");

  gate_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gate_o |-> ($past(count_register_r) == ebt_pkg::COUNT_TOP)
      && (count_register_r == 8'h00))
    else $error("gate pulse without rollover");

  gate_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ovf |=> gate_o)
    else $error("rollover gave no gate pulse");

  stat_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ovf |=> irq_stat_r)
    else $error("rollover did not raise the status bit");

  stat_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && (addr_i == ebt_pkg::OFS_IRQ_STAT) && !ovf |=> !irq_stat_r)
    else $error("status read did not clear the bit");

  irq_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_stat_r && irq_mask_r |=> irq_o)
    else $error("unmasked status gave no interrupt");

  irq_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !irq_mask_r |=> !irq_o)
    else $error("masked status reached the interrupt");

  read_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && (addr_i == ebt_pkg::OFS_COUNT) |=> rdata_o == $past(count_register_r))
    else $error("count read returned wrong value");

  read_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood outside its cycle");

endmodule

// [ebt_timer_tb.sv]
// Self-checking bench for the eight bit timer.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module ebt_timer_tb;
  logic       mclk_i;
  logic       rst_n_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       ext;
  logic       irq_o;
  logic       gate_o;
  logic       start;
  logic [7:0] pulses;
  logic       level;
  logic       busy;
  logic [7:0] v;
  int         mismatches;
  int         check_count;
  int         gates;
  int         d;

  ebt_timer i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_count_input_i(ext),
    .irq_o(irq_o), .gate_o(gate_o));
  ebt_count_src i_src (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start),
    .pulses_i(pulses), .level_i(level), .line_o(ext), .busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic idle(input int c);
    repeat (c) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= dt;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic chk_rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    `CHK(n, e, v)
  endtask

  // A zero pulse count only moves the line to the given level.
  task automatic src(input logic [7:0] n, input logic l);
    @(posedge mclk_i);
    start  <= 1'b1;
    pulses <= n;
    level  <= l;
    @(posedge mclk_i);
    start <= 1'b0;
    #1;
    for (d = 0; d < 200 && busy === 1'b1; d++) @(posedge mclk_i);
    idle(12);
  endtask

  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    if (gate_o === 1'b1) begin
      gates++;
    end
  end

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    start = 1'b0;
    pulses = 8'h00;
    level = 1'b0;
    mismatches = 0;
    check_count = 0;
    gates = 0;
    idle(6);
    rst_n_i <= 1'b1;
    chk_rd("option", 4'h1, 8'h3F);
    chk_rd("count", 4'h0, 8'h00);
    chk_rd("unmapped", 4'h7, 8'h00);
    // Window holds 3d+2 instruction cycles, so each rate yields three ticks.
    for (int r = 0; r <= 8; r++) begin
      d = (r == 8) ? 1 : 2 << r;
      wr(4'h1, (r == 8) ? 8'h08 : 8'(r));
      wr(4'h0, 8'h00);
      idle(4 * (3 * d + 2));
      chk_rd("timer count", 4'h0, 8'h03);
    end
    wr(4'h1, 8'h08);
    wr(4'h0, 8'hFE);
    gates = 0;
    idle(20);
    `CHK("gate pulses", 1, gates)
    chk_rd("flag", 4'h2, 8'h01);
    `CHK("irq masked", 1'b0, irq_o)
    wr(4'h4, 8'h01);
    idle(2);
    `CHK("irq", 1'b1, irq_o)
    chk_rd("status", 4'h3, 8'h01);
    chk_rd("flag kept", 4'h2, 8'h01);
    wr(4'h2, 8'h02);
    idle(2);
    `CHK("irq cleared", 1'b0, irq_o)
    chk_rd("status cleared", 4'h3, 8'h00);
    chk_rd("flag cleared", 4'h2, 8'h02);
    for (int e = 0; e <= 1; e++) begin
      wr(4'h1, (e == 1) ? 8'h38 : 8'h28);
      wr(4'h0, 8'h00);
      idle(12);
      src(8'h00, 1'b1);
      chk_rd("rise", 4'h0, (e == 1) ? 8'h00 : 8'h01);
      src(8'h00, 1'b0);
      chk_rd("fall", 4'h0, 8'h01);
    end
    wr(4'h1, 8'h20);
    wr(4'h0, 8'h00);
    idle(12);
    src(8'h06, 1'b0);
    chk_rd("prescaled count", 4'h0, 8'h03);
    results();
  end
endmodule
